/* File: shared/hop_consts.vh */
// Constants for the highside output protection and monitor control block.
`ifndef HOP_CONSTS_VH
`define HOP_CONSTS_VH

// ----------------------------------------------------------------------
// Control register layout
// ----------------------------------------------------------------------
`define HOP_CTRL_WIDTH 16
`define HOP_CTRL_RESET 16'h0000
`define HOP_OCR_EN_MSB 15
`define HOP_MOD_EN_MSB 10
`define HOP_OCR_FREQ_BIT 5
`define HOP_SUPPLY_LATCH_BIT 4
`define HOP_MON_SEL_MSB 3
`define HOP_MON_SEL_LSB 0

// ----------------------------------------------------------------------
// Output group and modulation routing
// ----------------------------------------------------------------------
`define HOP_NUM_OUT 5
`define HOP_SECOND_MOD_MASK 5'h0A
`define HOP_MON_OUTPUTS 11
`define HOP_MON_LAST_CODE 4'hA

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HOP_CLK_HZ 10000000
`define HOP_OCR_SLOW_HZ 1700
`define HOP_OCR_FAST_HZ 3000
`define HOP_OCR_SLOW_CYC (`HOP_CLK_HZ / `HOP_OCR_SLOW_HZ)
`define HOP_OCR_FAST_CYC (`HOP_CLK_HZ / `HOP_OCR_FAST_HZ)
`define HOP_OCR_CNT_W 13

`endif

/* File: core/hop_ctrl.v */
// Protection and modulation gating for outputs 7-11, current monitor select for outputs 1-11.
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`include "hop_consts.vh"

module hop_ctrl #(
    parameter integer OCR_SLOW_CYC = `HOP_OCR_SLOW_CYC,
    parameter integer OCR_FAST_CYC = `HOP_OCR_FAST_CYC
) (
    // Clock and reset
    input wire clk_sys,
    input wire nrst,
    // Control register write and read back
    input wire ctrlWrEn,
    input wire [15:0] ctrlWrData,
    output reg [15:0] ctrlRdData,
    // Output enables from the other control registers, index 0 is output 7
    input wire [4:0] outEnable,
    // Over-current detection and host clear of the flags
    input wire [4:0] ocDetect,
    input wire [4:0] ocFlagClr,
    output reg [4:0] ocFlag,
    // Supply fault and host clear of the status register
    input wire supplyFault,
    input wire supplyStatClr,
    output reg supplyOffFlag,
    // Modulation inputs
    input wire firstModIn,
    input wire secondModIn,
    // Driver switch commands, index 0 is output 7
    output reg [4:0] driveOn,
    // Current image monitor routing, index 0 is output 1
    output reg [10:0] monitorRoute,
    output reg monitorOn
);

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    reg [15:0] ctrl_q;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `HOP_CTRL_RESET;
        end else if (ctrlWrEn) begin
            ctrl_q <= ctrlWrData;
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrlRdData <= `HOP_CTRL_RESET;
        end else begin
            ctrlRdData <= ctrl_q;
        end
    end

    wire fastRate;
    wire supplyLatchSel;
    wire [3:0] monSel;

    assign fastRate = ctrl_q[`HOP_OCR_FREQ_BIT];
    assign supplyLatchSel = ctrl_q[`HOP_SUPPLY_LATCH_BIT];
    assign monSel = ctrl_q[`HOP_MON_SEL_MSB:`HOP_MON_SEL_LSB];

    // ------------------------------------------------------------------
    // Recovery rate divider
    // ------------------------------------------------------------------
    // The tick is the shared internal clock phase for all recoveries, so
    // a tripped output waits between one and a full period before restart.
    localparam integer SLOW_LAST_I = OCR_SLOW_CYC - 1;
    localparam integer FAST_LAST_I = OCR_FAST_CYC - 1;
    localparam [12:0] SLOW_LAST = SLOW_LAST_I[12:0];
    localparam [12:0] FAST_LAST = FAST_LAST_I[12:0];

    reg [12:0] rateCnt_q;
    reg recTick_q;
    wire [12:0] rateLast;

    assign rateLast = fastRate ? FAST_LAST : SLOW_LAST;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rateCnt_q <= 13'h0000;
            recTick_q <= 1'b0;
        end else if (rateCnt_q >= rateLast) begin
            rateCnt_q <= 13'h0000;
            recTick_q <= 1'b1;
        end else begin
            rateCnt_q <= rateCnt_q + 13'h0001;
            recTick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Supply fault latch
    // ------------------------------------------------------------------
    // A new fault in the clearing cycle keeps the latch set.
    reg supplyLatch_q;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            supplyLatch_q <= 1'b0;
        end else if (supplyFault && supplyLatchSel) begin
            supplyLatch_q <= 1'b1;
        end else if (supplyStatClr || !supplyLatchSel) begin
            supplyLatch_q <= 1'b0;
        end
    end

    wire supplyOff;

    assign supplyOff = supplyFault | supplyLatch_q;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            supplyOffFlag <= 1'b0;
        end else begin
            supplyOffFlag <= supplyOff;
        end
    end

    // ------------------------------------------------------------------
    // Per-output protection and modulation gating
    // ------------------------------------------------------------------
    reg [4:0] tripped_q;
    reg [4:0] ocFlag_q;
    wire [4:0] modMask;

    assign modMask = `HOP_SECOND_MOD_MASK;

    genvar i;
    generate
        for (i = 0; i < `HOP_NUM_OUT; i = i + 1) begin : g_out
            wire ocrEn;
            wire modEn;
            wire modIn;
            wire gate;

            assign ocrEn = ctrl_q[`HOP_OCR_EN_MSB - i];
            assign modEn = ctrl_q[`HOP_MOD_EN_MSB - i];
            assign modIn = modMask[i] ? secondModIn : firstModIn;
            assign gate = modEn ? modIn : 1'b1;

            // Sticky flag: detection wins over a host clear.
            always @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    ocFlag_q[i] <= 1'b0;
                end else if (ocDetect[i]) begin
                    ocFlag_q[i] <= 1'b1;
                end else if (ocFlagClr[i]) begin
                    ocFlag_q[i] <= 1'b0;
                end
            end

            // A trip in the tick cycle gets one restart on the spot.
            always @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    tripped_q[i] <= 1'b0;
                end else if (ocDetect[i] && recTick_q) begin
                    tripped_q[i] <= 1'b0;
                end else if (ocDetect[i]) begin
                    tripped_q[i] <= 1'b1;
                end else if (recTick_q && ocrEn) begin
                    tripped_q[i] <= 1'b0;
                end else if (ocFlagClr[i]) begin
                    tripped_q[i] <= 1'b0;
                end
            end

            always @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    driveOn[i] <= 1'b0;
                end else begin
                    driveOn[i] <= outEnable[i] & gate & ~supplyOff &
                        ~tripped_q[i] & ~ocDetect[i];
                end
            end
        end
    endgenerate

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ocFlag <= 5'h00;
        end else begin
            ocFlag <= ocFlag_q;
        end
    end

    // ------------------------------------------------------------------
    // Current image monitor selector
    // ------------------------------------------------------------------
    wire monValid;
    wire [10:0] monOneHot;

    assign monValid = (monSel <= `HOP_MON_LAST_CODE);
    assign monOneHot = 11'h001 << monSel;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            monitorRoute <= 11'h000;
            monitorOn <= 1'b0;
        end else if (monValid) begin
            monitorRoute <= monOneHot;
            monitorOn <= 1'b1;
        end else begin
            monitorRoute <= 11'h000;
            monitorOn <= 1'b0;
        end
    end

endmodule // hop_ctrl

/* File: testbench/hop_host.sv */
// Host model that writes the control register and clears status flags.
module hop_host (
    // Clock
    input wire logic clk_sys,
    // Register write and status clears
    output logic ctrlWrEn = 1'b0,
    output logic [15:0] ctrlWrData = 16'hFFFF,
    output logic [4:0] ocFlagClr = 5'h00,
    output logic supplyStatClr = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released data shows the inverse so stale values are never reused.
    task automatic pulse(input logic [15:0] d, input logic [4:0] oc,
                         input logic st);
        @(posedge clk_sys);
        #1;
        ctrlWrEn = ~|oc & ~st;
        ctrlWrData = d;
        ocFlagClr = oc;
        supplyStatClr = st;
        @(posedge clk_sys);
        #1;
        ctrlWrEn = 1'b0;
        ocFlagClr = 5'h00;
        supplyStatClr = 1'b0;
        ctrlWrData = ~d;
    endtask
endmodule // hop_host

/* File: testbench/hop_ctrl_chk.sv */
// Concurrent checks on the ports of the control block.
module hop_ctrl_chk (
    input wire clk_sys,
    input wire nrst,
    input wire ctrlWrEn,
    input wire [15:0] ctrlWrData,
    input wire [15:0] ctrlRdData,
    input wire [4:0] outEnable,
    input wire [4:0] ocDetect,
    input wire [4:0] ocFlag,
    input wire supplyFault,
    input wire supplyStatClr,
    input wire supplyOffFlag,
    input wire firstModIn,
    input wire secondModIn,
    input wire [4:0] driveOn,
    input wire [10:0] monitorRoute,
    input wire monitorOn
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_wr; ctrlWrEn ##2 1'b1; endsequence
    property p_rd; s_wr |-> ctrlRdData == $past(ctrlWrData, 2); endproperty
    // The flag output is a registered copy, so it shows two edges later.
    property p_oc; ocDetect != 5'h00 |-> ##2
        (ocFlag & $past(ocDetect, 2)) == $past(ocDetect, 2); endproperty
    property p_sup; supplyFault |=> driveOn == 5'h00 && supplyOffFlag;
    endproperty
    property p_lat; ctrlRdData[4] && supplyOffFlag && !$past(supplyStatClr)
        && !supplyFault |=> supplyOffFlag; endproperty
    property p_mon; $past(nrst) |-> monitorOn == (ctrlRdData[3:0] < 4'hB);
    endproperty
    property p_rte; monitorRoute ==
        (monitorOn ? 11'h001 << ctrlRdData[3:0] : 11'h000); endproperty
    property p_dis; (driveOn & ~$past(outEnable)) == 5'h00; endproperty
    property p_m1; ctrlRdData[10] && !$past(firstModIn) |-> !driveOn[0];
    endproperty
    property p_m2; ctrlRdData[9] && !$past(secondModIn) |-> !driveOn[1];
    endproperty
    a_rd: assert property (p_rd) else $error("read back wrong");
    a_oc: assert property (p_oc) else $error("trip flag missing");
    a_sup: assert property (p_sup) else $error("supply off");
    a_lat: assert property (p_lat) else $error("latch dropped");
    a_mon: assert property (p_mon) else $error("monitor on");
    a_rte: assert property (p_rte) else $error("route wrong");
    a_dis: assert property (p_dis) else $error("disabled on");
    a_m1: assert property (p_m1) else $error("first gate");
    a_m2: assert property (p_m2) else $error("second gate");
endmodule // hop_ctrl_chk
bind hop_ctrl hop_ctrl_chk i_chk (.*);

/* File: testbench/tb.sv */
// Self-checking bench for the output protection and monitor block.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, nrst = 0, supplyFault = 0;
    logic firstModIn = 0, secondModIn = 0;
    logic [4:0] outEnable = 0, ocDetect = 0;
    wire ctrlWrEn, supplyStatClr, supplyOffFlag, monitorOn;
    wire [15:0] ctrlWrData, ctrlRdData;
    wire [4:0] ocFlagClr, ocFlag, driveOn;
    wire [10:0] monitorRoute;
    int errors = 0, cmp_count = 0, c, d;
    int unsigned seed = 811;
    hop_ctrl #(.OCR_SLOW_CYC(20), .OCR_FAST_CYC(10)) i_dut (.clk_sys,
        .nrst, .ctrlWrEn, .ctrlWrData, .ctrlRdData, .outEnable, .ocDetect,
        .ocFlagClr, .ocFlag, .supplyFault, .supplyStatClr, .supplyOffFlag,
        .firstModIn, .secondModIn, .driveOn, .monitorRoute, .monitorOn);
    hop_host i_host (.clk_sys, .ctrlWrEn, .ctrlWrData, .ocFlagClr,
        .supplyStatClr);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [11:0] expMon(input int k);
        return (k < 11) ? {1'b1, 11'(1 << k)} : 12'h000;
    endfunction
    // Outputs 8 and 10 sit at odd indices and follow the second input.
    function automatic logic [4:0] expDrv(input int e, input int m);
        logic [4:0] r;
        for (int i = 0; i < 5; i++)
            r[i] = e[i] & (~m[10-i] | ((i % 2) ? e[6] : e[5]));
        return r;
    endfunction
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        #500000;
        errors++;
        tally_and_finish();
    end
    initial begin
        tick(16);
        nrst = 1;
        tick(1);
        chk(ctrlRdData, 16'h0000);
        chk({monitorOn, monitorRoute}, expMon(0));
        for (int k = 0; k < 16; k++) begin
            c = (xs() & 16'hFFE0) | k;
            i_host.pulse(c[15:0], 5'h00, 1'b0);
            tick(2);
            chk(ctrlRdData, c[15:0]);
            chk({monitorOn, monitorRoute}, expMon(k));
            chk(driveOn, 5'h00);
        end
        for (int k = 0; k < 12; k++) begin
            c = xs();
            d = c & 16'h07C0;
            i_host.pulse(d[15:0], 5'h00, 1'b0);
            outEnable = c[4:0];
            firstModIn = c[5];
            secondModIn = c[6];
            tick(2);
            chk(driveOn, expDrv(c, d));
        end
        // A second reset puts the recovery tick at a known phase.
        outEnable = 5'h1F;
        nrst = 0;
        tick(2);
        nrst = 1;
        tick(2);
        chk({ocFlag, driveOn}, 10'h01F);
        ocDetect = 5'h04;
        tick(2);
        ocDetect = 5'h00;
        tick(30);
        chk({ocFlag, driveOn}, 10'h09B);
        i_host.pulse(16'h0000, 5'h04, 1'b0);
        tick(2);
        chk({ocFlag, driveOn}, 10'h01F);
        i_host.pulse(16'h2020, 5'h00, 1'b0);
        ocDetect = 5'h04;
        tick(2);
        ocDetect = 5'h00;
        chk(driveOn, 5'h1B);
        for (c = 0; c < 14 && driveOn[2] !== 1'b1; c++)
            tick(1);
        chk(c[15:0], 16'h000A);
        chk({ocFlag, driveOn}, 10'h09F);
        i_host.pulse(16'h0010, 5'h04, 1'b0);
        i_host.pulse(16'h0010, 5'h00, 1'b0);
        supplyFault = 1;
        tick(3);
        supplyFault = 0;
        tick(5);
        chk({supplyOffFlag, driveOn}, 6'h20);
        i_host.pulse(16'h0000, 5'h00, 1'b1);
        tick(3);
        chk({supplyOffFlag, driveOn}, 6'h1F);
        // A one-cycle trip on the tick edge restarts with recovery off.
        tick(1);
        ocDetect = 5'h01;
        tick(1);
        ocDetect = 5'h00;
        tick(2);
        chk({ocFlag, driveOn}, 10'h03F);
        tally_and_finish();
    end
endmodule // tb
